// [logic/async_timer16.sv]
// Async-capable 16-bit timer with APB control, period match and interrupt.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module async_timer16 #(
  parameter int WR_SYNC_CYCLES = 2
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          clk_en,
  input  wire async_timer16_pkg::apb_req_type apb_req,
  output logic                               pready,
  output logic                               pslverr,
  output logic [31:0]                        prdata,
  input  wire logic                          ext_timer_clock_pin,
  input  wire logic                          gate_in,
  input  wire logic                          idle_mode,
  input  wire logic                          sleep_mode,
  output logic                               irq,
  output logic [15:0]                        count_value
);
  import async_timer16_pkg::*;

  // The crossing counter is four bits wide and must count at least once.
  if (WR_SYNC_CYCLES < 1 || WR_SYNC_CYCLES > 8) begin : g_bad_sync
    $error("WR_SYNC_CYCLES out of range");
  end

  // Decode an alias operation onto a register value.
  function automatic logic [15:0] apply_alias(input logic [15:0] cur, input logic [15:0] wd,
                                               input logic [1:0] op);
    logic [15:0] r;
    r = wd;
    unique case (op)
      ALIAS_NONE: r = wd;
      ALIAS_CLR:  r = cur & ~wd;
      ALIAS_SET:  r = cur | wd;
      ALIAS_INV:  r = cur ^ wd;
    endcase
    return r;
  endfunction

  // Map a prescale field code to its terminal count.
  function automatic logic [7:0] ps_term(input logic [1:0] sel);
    logic [7:0] t;
    t = PS_DIV1;
    unique case (sel)
      2'h0: t = PS_DIV1;
      2'h1: t = PS_DIV8;
      2'h2: t = PS_DIV64;
      2'h3: t = PS_DIV256;
    endcase
    return t;
  endfunction

  state_type s_r;
  state_type s_nxt;

  logic        acc;
  logic        wr_acc;
  logic [3:0]  base;
  logic [1:0]  op;
  logic        on_b;
  logic        ext_sel;
  logic        async_mode;
  logic        gated;
  logic        run;
  logic        src_tick;
  logic        tick;
  logic        pending;
  logic [15:0] ctrl_rd;
  logic [15:0] ctrl_w;
  logic [3:0]  sync_cnt_r;
  logic [3:0]  sync_cnt_nxt;

  // Access decode: the top nibble of the low byte picks the register, the
  // address bits 3:2 the alias.
  assign acc        = apb_req.psel && apb_req.penable;
  assign wr_acc     = acc && apb_req.pwrite;
  assign base       = apb_req.paddr[7:4];
  assign op         = apb_req.paddr[3:2];
  assign pready     = 1'b1;
  assign on_b       = s_r.ctrl[ON_BIT];
  assign ext_sel    = s_r.ctrl[CLK_SRC_BIT];
  assign async_mode = ext_sel && !s_r.ctrl[SYNC_BIT];
  assign gated      = !ext_sel && s_r.ctrl[GATE_BIT];
  assign pending    = (s_r.wr_state != WR_IDLE);

  // Idle halts only with bit 13 set; sleep halts everything but async mode.
  // Both power states are plain levels from the system; the timer does not
  // latch them, so leaving idle resumes counting on the very next tick.
  assign run = on_b && !(idle_mode && s_r.ctrl[IDLE_STOP_BIT])
             && !(sleep_mode && !async_mode);

  // Source edge: external rising edge through the synchroniser pair, or the
  // peripheral clock itself. The async path also uses the resynchronised edge
  // since this model has one clock; the pending flag models the crossing delay.
  assign src_tick = ext_sel ? (s_r.ext_s2 && !s_r.ext_prev)
                            : (!gated || gate_in);
  assign tick = run && src_tick && (s_r.presc == ps_term(s_r.ctrl[PS_HI_BIT:PS_LO_BIT]));

  // Read view of the control word; write-pending reads zero when synchronous.
  always_comb begin
    ctrl_rd = s_r.ctrl & CTRL_WMASK[15:0];
    // The pending flag is only meaningful while the counter is clocked
    // asynchronously; in every synchronous mode software must see zero.
    ctrl_rd[WR_PEND_BIT] = async_mode && pending;
  end

  assign ctrl_w = apply_alias(s_r.ctrl, apb_req.pwdata[15:0], op) & CTRL_WMASK[15:0];

  // Next-state logic for all timer state.
  always_comb begin
    s_nxt = s_r;
    sync_cnt_nxt = sync_cnt_r;
    pslverr = 1'b0;
    s_nxt.ext_s1   = ext_timer_clock_pin;
    s_nxt.ext_s2   = s_r.ext_s1;
    s_nxt.ext_prev = s_r.ext_s2;
    s_nxt.gate_prev = gate_in;

    // Prescaler counts source edges; cleared when the timer is off.
    if (!on_b) begin
      s_nxt.presc = '0;
    end else if (run && src_tick) begin
      s_nxt.presc = tick ? '0 : s_r.presc + 8'h01;
    end

    // Counter increments per tick and wraps after matching the period.
    if (tick) begin
      if (s_r.count == s_r.period) begin
        s_nxt.count = '0;
        s_nxt.irq_stat[IRQ_PERIOD_BIT] = 1'b1;
      end else begin
        s_nxt.count = s_r.count + 16'h0001;
      end
    end

    // Falling gate edge ends an accumulation window.
    if (on_b && gated && s_r.gate_prev && !gate_in) begin
      s_nxt.irq_stat[IRQ_GATE_BIT] = 1'b1;
    end

    // Pending async write lands after the crossing delay.
    if (s_r.wr_state == WR_WAIT) begin
      if (sync_cnt_r == 4'(WR_SYNC_CYCLES - 1)) begin
        s_nxt.count = s_r.wr_data;
        s_nxt.wr_state = WR_DONE;
      end else begin
        sync_cnt_nxt = sync_cnt_r + 4'h1;
      end
    end else if (s_r.wr_state == WR_DONE) begin
      s_nxt.wr_state = WR_IDLE;
    end

    // Register writes.
    if (wr_acc) begin
      unique case (base)
        CTRL_OFS[7:4]: s_nxt.ctrl = ctrl_w;
        COUNT_OFS[7:4]: begin
          if (async_mode) begin
            // With the block bit set, a write during a crossing is dropped.
            // With the block bit clear a new write simply restarts the crossing,
            // which is the legacy behaviour; the earlier value is then lost.
            if (!(pending && s_r.ctrl[WR_BLOCK_BIT])) begin
              s_nxt.wr_data  = apply_alias(s_r.count, apb_req.pwdata[15:0], op);
              s_nxt.wr_state = WR_WAIT;
              sync_cnt_nxt   = '0;
            end
          end else begin
            s_nxt.count = apply_alias(s_r.count, apb_req.pwdata[15:0], op);
          end
        end
        PERIOD_OFS[7:4]: s_nxt.period = apply_alias(s_r.period, apb_req.pwdata[15:0], op);
        IRQ_STAT_OFS[7:4]: begin
          // Write one to clear; a same-cycle event wins only on a flag that was clear.
          s_nxt.irq_stat = (s_r.irq_stat & ~apb_req.pwdata[IRQ_W-1:0]) |
                           (s_nxt.irq_stat & ~s_r.irq_stat);
        end
        IRQ_MASK_OFS[7:4]: s_nxt.irq_mask = apb_req.pwdata[IRQ_W-1:0];
        default: pslverr = 1'b1;
      endcase
    end

    // Read data registered at the access edge.
    if (acc && !apb_req.pwrite) begin
      unique case (base)
        CTRL_OFS[7:4]:     s_nxt.prdata = {16'h0000, ctrl_rd};
        COUNT_OFS[7:4]:    s_nxt.prdata = {16'h0000, s_r.count};
        PERIOD_OFS[7:4]:   s_nxt.prdata = {16'h0000, s_r.period};
        IRQ_STAT_OFS[7:4]: s_nxt.prdata = {30'h0, s_r.irq_stat};
        IRQ_MASK_OFS[7:4]: s_nxt.prdata = {30'h0, s_r.irq_mask};
        default: begin
          s_nxt.prdata = 32'h0000_0000;
          pslverr = 1'b1;
        end
      endcase
    end
  end

  // State register; clock enable freezes everything.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '{ctrl: CTRL_RST, count: 16'h0000, period: PERIOD_RST, irq_stat: '0,
               irq_mask: '0, presc: 8'h00, ext_s1: 1'b0, ext_s2: 1'b0, ext_prev: 1'b0,
               gate_prev: 1'b0, wr_data: 16'h0000, wr_state: WR_IDLE, prdata: 32'h0};
      sync_cnt_r <= 4'h0;
    end else if (clk_en) begin
      s_r <= s_nxt;
      sync_cnt_r <= sync_cnt_nxt;
    end
  end

  // Read data combinationally from the live state so it is valid at the access edge.
  always_comb begin
    prdata = 32'h0000_0000;
    if (acc && !apb_req.pwrite) begin
      unique case (base)
        CTRL_OFS[7:4]:     prdata = {16'h0000, ctrl_rd};
        COUNT_OFS[7:4]:    prdata = {16'h0000, s_r.count};
        PERIOD_OFS[7:4]:   prdata = {16'h0000, s_r.period};
        IRQ_STAT_OFS[7:4]: prdata = {30'h0, s_r.irq_stat};
        IRQ_MASK_OFS[7:4]: prdata = {30'h0, s_r.irq_mask};
        default:           prdata = 32'h0000_0000;
      endcase
    end
  end

  assign irq = |(s_r.irq_stat & s_r.irq_mask);
  assign count_value = s_r.count;

  // Assertions. Each one watches state or outputs that the logic above drives.
  // Antecedents, other than those of a_wrap_flag and a_gate_flag, leave out cycles with a competing register write, since such a
  // write legally overrides whatever the counting path would have done then.

  // Write-pending must never show outside the asynchronous mode.
  a_pend_sync_zero: assert property (@(posedge clk) disable iff (rst)
    !async_mode |-> !ctrl_rd[WR_PEND_BIT]) else $error("write pending set in sync mode");

  // A disabled timer holds its count unless software or a crossing writes it.
  a_off_no_count: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !on_b && !(wr_acc && base == COUNT_OFS[7:4]) && s_r.wr_state != WR_WAIT)
    |=> $stable(s_r.count)) else $error("counter moved while off");

  // Stop-in-idle must suppress every tick while idle is asserted.
  a_idle_stop: assert property (@(posedge clk) disable iff (rst)
    (idle_mode && s_r.ctrl[IDLE_STOP_BIT]) |-> !tick) else $error("tick during idle stop");

  // A tick at the period value must raise the period flag.
  a_wrap_flag: assert property (@(posedge clk) disable iff (rst)
    (clk_en && tick && s_r.count == s_r.period) |=> s_r.irq_stat[IRQ_PERIOD_BIT])
    else $error("period match did not flag");

  // A blocked write must leave the value in flight untouched.
  a_write_block: assert property (@(posedge clk) disable iff (rst)
    (clk_en && wr_acc && base == COUNT_OFS[7:4] && async_mode && pending
     && s_r.ctrl[WR_BLOCK_BIT] && s_r.wr_state == WR_WAIT) |=> $stable(s_r.wr_data))
    else $error("blocked write accepted");

  // Every register is sixteen bits or less, so the upper half reads zero.
  a_hi_zero: assert property (@(posedge clk) disable iff (rst)
    prdata[31:16] == 16'h0000) else $error("upper bits not zero");

  // With the gate low a gated timer must not advance.
  a_gate_hold: assert property (@(posedge clk) disable iff (rst)
    (gated && !gate_in) |-> !tick) else $error("gated count while gate low");

  // The gate input has no effect at all on the external source.
  a_ext_no_gate: assert property (@(posedge clk) disable iff (rst)
    (ext_sel && clk_en && on_b && s_r.gate_prev && !gate_in
     && !(wr_acc && base == IRQ_STAT_OFS[7:4]) && !s_r.irq_stat[IRQ_GATE_BIT])
    |=> !s_r.irq_stat[IRQ_GATE_BIT]) else $error("gate event with external clock");

  // The interrupt line follows the masked status level.
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    irq == |(s_r.irq_stat & s_r.irq_mask)) else $error("irq mismatch");

  // Below the period a tick adds exactly one.
  a_count_step: assert property (@(posedge clk) disable iff (rst)
    (clk_en && tick && s_r.count != s_r.period && s_r.wr_state != WR_WAIT
     && !(wr_acc && base == COUNT_OFS[7:4]))
    |=> s_r.count == $past(s_r.count) + 16'h0001) else $error("count step wrong");

  // No tick at all while the enable bit is clear.
  a_off_no_tick: assert property (@(posedge clk) disable iff (rst)
    !on_b |-> !tick) else $error("tick while disabled");

  // A crossing in asynchronous mode must be visible to software.
  a_pend_shown: assert property (@(posedge clk) disable iff (rst)
    (async_mode && pending) |-> ctrl_rd[WR_PEND_BIT]) else $error("pending not shown");

  // The crossing delivers the written value when its counter expires.
  a_pend_lands: assert property (@(posedge clk) disable iff (rst)
    (clk_en && s_r.wr_state == WR_WAIT && sync_cnt_r == 4'(WR_SYNC_CYCLES - 1)
     && !(wr_acc && base == COUNT_OFS[7:4]))
    |=> s_r.count == $past(s_r.wr_data)) else $error("async write did not land");

  // The done state lasts one cycle, after which pending reads clear.
  a_pend_clears: assert property (@(posedge clk) disable iff (rst)
    (clk_en && s_r.wr_state == WR_DONE && !wr_acc) |=> !pending)
    else $error("pending did not clear");

  // With the block bit clear every counter write in asynchronous mode starts a fresh crossing.
  a_b2b_accept: assert property (@(posedge clk) disable iff (rst)
    (clk_en && wr_acc && base == COUNT_OFS[7:4] && async_mode && !s_r.ctrl[WR_BLOCK_BIT])
    |=> (s_r.wr_state == WR_WAIT && sync_cnt_r == 4'h0)) else $error("write not accepted");

  // Between ticks the prescaler counts every qualified source edge.
  a_presc_step: assert property (@(posedge clk) disable iff (rst)
    (clk_en && on_b && run && src_tick && !tick)
    |=> s_r.presc == $past(s_r.presc) + 8'h01) else $error("prescaler step wrong");

  // An ungated internal source ticks whenever the timer runs and the prescaler is at terminal count.
  a_int_tick: assert property (@(posedge clk) disable iff (rst)
    (!ext_sel && !gated && run && s_r.presc == ps_term(s_r.ctrl[PS_HI_BIT:PS_LO_BIT]))
    |-> tick) else $error("internal tick missing");

  // The external source ticks only on a resynchronised rising edge.
  a_ext_edge: assert property (@(posedge clk) disable iff (rst)
    (ext_sel && !(s_r.ext_s2 && !s_r.ext_prev)) |-> !tick) else $error("ext tick off edge");

  // The sync select has no meaning with the internal clock.
  a_sync_ignored: assert property (@(posedge clk) disable iff (rst)
    !ext_sel |-> !async_mode) else $error("async mode on internal clock");

  // A set alias raises every selected writable bit.
  a_alias_set: assert property (@(posedge clk) disable iff (rst)
    (clk_en && wr_acc && base == CTRL_OFS[7:4] && op == ALIAS_SET)
    |=> (s_r.ctrl & $past(apb_req.pwdata[15:0]) & CTRL_WMASK[15:0])
        == ($past(apb_req.pwdata[15:0]) & CTRL_WMASK[15:0])) else $error("set alias failed");

  // A clear alias drops every selected bit.
  a_alias_clr: assert property (@(posedge clk) disable iff (rst)
    (clk_en && wr_acc && base == CTRL_OFS[7:4] && op == ALIAS_CLR)
    |=> (s_r.ctrl & $past(apb_req.pwdata[15:0])) == 16'h0000) else $error("clr alias failed");

  // Sleep halts the synchronous modes, which need the stopped peripheral clock.
  a_sleep_stop: assert property (@(posedge clk) disable iff (rst)
    (sleep_mode && !async_mode) |-> !tick) else $error("sync tick in sleep");

  // The asynchronous mode keeps running through sleep.
  a_sleep_async: assert property (@(posedge clk) disable iff (rst)
    (sleep_mode && async_mode && on_b && !(idle_mode && s_r.ctrl[IDLE_STOP_BIT]))
    |-> run) else $error("async mode halted in sleep");

  // A gate fall in gated mode must raise the gate flag.
  a_gate_flag: assert property (@(posedge clk) disable iff (rst)
    (clk_en && on_b && gated && s_r.gate_prev && !gate_in) |=> s_r.irq_stat[IRQ_GATE_BIT])
    else $error("gate fall did not flag");

  // Control bits outside the implemented set never read as one.
  a_unimpl_zero: assert property (@(posedge clk) disable iff (rst)
    (ctrl_rd & ~CTRL_WMASK[15:0] & ~(16'h0001 << WR_PEND_BIT)) == 16'h0000)
    else $error("unimplemented bit set");

  // A low clock enable freezes every bit of state.
  a_freeze: assert property (@(posedge clk) disable iff (rst)
    !clk_en |=> $stable(s_r)) else $error("state moved while frozen");

  // The registered copy of read data tracks what the bus saw.
  a_rd_copy: assert property (@(posedge clk) disable iff (rst)
    (clk_en && acc && !apb_req.pwrite) |=> s_r.prdata == $past(prdata))
    else $error("read copy mismatch");

endmodule
`default_nettype wire

// [logic/async_timer16_pkg.sv]
// Package holding the register map, field layout and types of the async 16-bit timer.
package async_timer16_pkg;

  // Register word byte offsets on the APB bus.
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] CTRL_CLR_OFS  = 8'h04;
  localparam logic [7:0] CTRL_SET_OFS  = 8'h08;
  localparam logic [7:0] CTRL_INV_OFS  = 8'h0C;
  localparam logic [7:0] COUNT_OFS     = 8'h10;
  localparam logic [7:0] PERIOD_OFS    = 8'h20;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h30;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h40;

  // Set, clear and invert alias codes, carried in address bits 3:2 above the control, count and period bases.
  localparam logic [1:0] ALIAS_NONE = 2'h0;
  localparam logic [1:0] ALIAS_CLR  = 2'h1;
  localparam logic [1:0] ALIAS_SET  = 2'h2;
  localparam logic [1:0] ALIAS_INV  = 2'h3;

  // Control register field positions.
  localparam int ON_BIT    = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int WR_BLOCK_BIT  = 12;
  localparam int WR_PEND_BIT   = 11;
  localparam int GATE_BIT  = 7;
  localparam int PS_HI_BIT = 5;
  localparam int PS_LO_BIT = 4;
  localparam int SYNC_BIT  = 2;
  localparam int CLK_SRC_BIT = 1;

  // Writable bits of the control register; everything else reads zero except the write-pending bit 11.
  localparam logic [31:0] CTRL_WMASK = 32'h0000_B0B6;

  // Reset values.
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;

  // Interrupt status bit positions.
  localparam int IRQ_PERIOD_BIT = 0;
  localparam int IRQ_GATE_BIT   = 1;
  localparam int IRQ_W          = 2;

  // Prescaler terminal counts (divide minus one).
  localparam logic [7:0] PS_DIV1   = 8'h00;
  localparam logic [7:0] PS_DIV8   = 8'h07;
  localparam logic [7:0] PS_DIV64  = 8'h3F;
  localparam logic [7:0] PS_DIV256 = 8'hFF;

  // Write crossing handshake states; each step flips one bit except WR_DONE back to WR_IDLE.
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_WAIT = 2'b01,
    WR_DONE = 2'b11
  } wr_state_type;

  // All state of the timer but the crossing counter.
  typedef struct packed {
    logic [15:0]       ctrl;
    logic [15:0]       count;
    logic [15:0]       period;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    logic [7:0]        presc;
    logic              ext_s1;
    logic              ext_s2;
    logic              ext_prev;
    logic              gate_prev;
    logic [15:0]       wr_data;
    wr_state_type      wr_state;
    logic [31:0]       prdata;
  } state_type;

  // APB request bundle.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

endpackage

// [verif/ext_clock_src.sv]
// Behavioural external clock source standing in for a slow secondary oscillator.
`timescale 1ns/10ps
`default_nettype none
module ext_clock_src #(
  parameter int HALF_NS = 37
) (
  input  wire logic run,
  output logic      pin
);
  // Toggles only while asked; between bursts the pin stands low so no stray edge is seen.
  initial begin
    pin = 1'b0;
    forever begin
      #(HALF_NS);
      pin = run ? ~pin : 1'b0;
    end
  end
endmodule
`default_nettype wire

// [verif/async_timer16_tb.sv]
// Self-checking testbench of the async 16-bit timer over APB.
`timescale 1ns/10ps
`default_nettype none
module async_timer16_tb;
  import async_timer16_pkg::*;
  logic        clk, rst, pready, pslverr, irq, ext_run, ext_pin, gate_in, idle_mode, er;
  logic        sleep_mode, clk_en;
  logic [31:0] prdata, rd;
  logic [15:0] count_value;
  apb_req_type req;
  int          n_fail, tests_run, n_edges;

  async_timer16 #(.WR_SYNC_CYCLES(8)) i_dut (.clk(clk), .rst(rst), .clk_en(clk_en), .apb_req(req),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .ext_timer_clock_pin(ext_pin),
    .gate_in(gate_in), .idle_mode(idle_mode), .sleep_mode(sleep_mode), .irq(irq),
    .count_value(count_value));
  ext_clock_src #(.HALF_NS(37)) i_src (.run(ext_run), .pin(ext_pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge ext_pin) n_edges++;

  task automatic final_report();
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkr(input string nm, input int lo, input int hi);
    tests_run++;
    if (!(count_value >= lo && count_value <= hi) || $isunknown(count_value)) begin
      n_fail++;
      $display("MISMATCH %s expected %0d..%0d seen %h", nm, lo, hi, count_value);
    end
  endtask
  // The request stands until the edge that samples pready high, where the answer
  // is taken; one idle cycle follows, so no access lands right after a disable.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        n_fail++;
        final_report();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_irq(input logic v);
    int n;
    for (n = 0; n < 20 && irq !== v; n++) @(posedge clk);
    chk("irq", {31'h0, v}, {31'h0, irq});
  endtask

  task automatic t_reset();
    rdc("ctrl", CTRL_OFS, 32'h0000_0000);
    rdc("count", COUNT_OFS, 32'h0000_0000);
    rdc("period", PERIOD_OFS, 32'h0000_FFFF);
    rdc("stat", IRQ_STAT_OFS, 32'h0000_0000);
    rdc("mask", IRQ_MASK_OFS, 32'h0000_0000);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h50, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    chk("bad_rd", 32'h0, rd);
  endtask
  task automatic t_ctrl();
    wr(CTRL_OFS, 32'hFFFF_FFFF);
    rdc("ctrl_all", CTRL_OFS, 32'h0000_B0B6);
    wr(CTRL_CLR_OFS, 32'hFFFF_FFFF);
    rdc("ctrl_clr", CTRL_OFS, 32'h0000_0000);
    wr(CTRL_SET_OFS, 32'h0000_0030);
    rdc("ctrl_set", CTRL_OFS, 32'h0000_0030);
    wr(CTRL_INV_OFS, 32'h0000_0010);
    rdc("ctrl_inv", CTRL_OFS, 32'h0000_0020);
  endtask
  // Each divisor runs 512 cycles; APB overhead adds a few ticks at most.
  task automatic t_prescale();
    int d;
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 1 : (i == 1) ? 8 : (i == 2) ? 64 : 256;
      wr(CTRL_OFS, 32'h0);
      wr(COUNT_OFS, 32'h0);
      wr(CTRL_OFS, 32'h8000 | (i << 4));
      cyc(512);
      wr(CTRL_OFS, 32'h0);
      chkr("prescale", 512 / d - 1, 524 / d + 1);
    end
  endtask
  task automatic t_wrap();
    wr(PERIOD_OFS, 32'h4);
    wr(IRQ_MASK_OFS, 32'h1);
    wr(COUNT_OFS, 32'h0);
    wr(CTRL_OFS, 32'h8000);
    wait_irq(1'b1);
    wr(CTRL_OFS, 32'h0);
    chkr("wrap", 0, 4);
    rdc("stat_wrap", IRQ_STAT_OFS, 32'h1);
    wr(IRQ_MASK_OFS, 32'h0);
    wait_irq(1'b0);
    wr(IRQ_MASK_OFS, 32'h1);
    wait_irq(1'b1);
    wr(IRQ_STAT_OFS, 32'h1);
    wait_irq(1'b0);
    rdc("stat_w1c", IRQ_STAT_OFS, 32'h0);
    wr(PERIOD_OFS, 32'hFFFF);
  endtask
  task automatic t_gate();
    wr(COUNT_OFS, 32'h0);
    wr(CTRL_OFS, 32'h8080);
    cyc(20);
    chkr("gate_low", 0, 0);
    gate_in <= 1'b1;
    cyc(20);
    gate_in <= 1'b0;
    cyc(5);
    chkr("gate_high", 16, 24);
    rdc("stat_gate", IRQ_STAT_OFS, 32'h2);
    wr(IRQ_STAT_OFS, 32'h3);
  endtask
  task automatic t_idle();
    wr(CTRL_OFS, 32'h0);
    wr(COUNT_OFS, 32'h0);
    idle_mode <= 1'b1;
    wr(CTRL_OFS, 32'hA000);
    cyc(20);
    chkr("idle_stop", 0, 0);
    wr(CTRL_OFS, 32'h8000);
    cyc(20);
    chkr("idle_run", 18, 30);
    idle_mode <= 1'b0;
  endtask
  // Gate stays low, so any count proves the gate is ignored on the external source.
  task automatic t_ext();
    wr(CTRL_OFS, 32'h0);
    wr(COUNT_OFS, 32'h0);
    wr(CTRL_OFS, 32'h8086);
    n_edges = 0;
    ext_run <= 1'b1;
    cyc(400);
    ext_run <= 1'b0;
    cyc(20);
    chk("ext_count", n_edges, {16'h0, count_value});
  endtask
  // Sleep stops the synchronous clock but not the async source; clk_en freezes all.
  task automatic t_sleep();
    wr(CTRL_OFS, 32'h0);
    wr(COUNT_OFS, 32'h0);
    sleep_mode <= 1'b1;
    wr(CTRL_OFS, 32'h8000);
    cyc(20);
    chkr("sleep_sync", 0, 0);
    wr(CTRL_OFS, 32'h8002);
    n_edges = 0;
    ext_run <= 1'b1;
    cyc(200);
    ext_run <= 1'b0;
    cyc(20);
    chk("sleep_async", n_edges, {16'h0, count_value});
    sleep_mode <= 1'b0;
    wr(CTRL_OFS, 32'h0);
    wr(COUNT_OFS, 32'h0);
    clk_en <= 1'b0;
    wr(CTRL_OFS, 32'h8000);
    cyc(20);
    chkr("frozen", 0, 0);
    rdc("ctrl_lost", CTRL_OFS, 32'h0000_0000);
    clk_en <= 1'b1;
  endtask
  task automatic t_async();
    wr(CTRL_OFS, 32'h9002);
    wr(COUNT_OFS, 32'h1234);
    rdc("pending", CTRL_OFS, 32'h9802);
    wr(COUNT_OFS, 32'h5555);
    cyc(30);
    rdc("blocked", COUNT_OFS, 32'h1234);
    rdc("done", CTRL_OFS, 32'h9002);
    wr(CTRL_OFS, 32'h8002);
    wr(COUNT_OFS, 32'h1111);
    wr(COUNT_OFS, 32'h2222);
    cyc(30);
    rdc("b2b", COUNT_OFS, 32'h2222);
  endtask

  initial begin
    n_fail    = 0;
    tests_run = 0;
    rst       = 1'b1;
    req       = '0;
    ext_run   = 1'b0;
    gate_in   = 1'b0;
    idle_mode = 1'b0;
    sleep_mode = 1'b0;
    clk_en    = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_prescale();
    t_wrap();
    t_gate();
    t_idle();
    t_ext();
    t_sleep();
    t_async();
    final_report();
  end
endmodule
`default_nettype wire
